/* core/frs_core.sv */
// fault log, urgent alert and emergency shutdown sequencer
// assumes error strobes and step acknowledges come from logic on clock_i;
// spi pins are asynchronous and are synchronised here
`timescale 1ns/100ps
`default_nettype none

module frs_core #(
   parameter int ERR_N     = frs_pkg::ERR_N_DEF,
   parameter int LOG_DEPTH = frs_pkg::LOG_DEPTH_DEF
) (
   input  wire logic             clock_i,
   input  wire logic             reset_i,
   input  wire logic [ERR_N-1:0] err_event_i,
   input  wire logic [ERR_N-1:0] err_serious_i,
   input  wire logic [ERR_N-1:0] err_critical_i,
   input  wire logic             light_off_done_i,
   input  wire logic             mirror_parked_i,
   input  wire logic             mirror_off_done_i,
   input  wire logic             spi_sck_i,
   input  wire logic             spi_cs_n_i,
   input  wire logic             spi_mosi_i,
   output logic                  alert_o,
   output logic                  light_off_o,
   output logic                  mirror_park_o,
   output logic                  mirror_pwr_off_o,
   output logic                  standby_o,
   output logic                  shutdown_o,
   output logic                  spi_miso_o,
   output logic                  spi_miso_oe_o
);
   import frs_pkg::*;

   localparam int PW = $clog2(LOG_DEPTH);
   localparam int IW = $clog2(ERR_N);
   localparam logic [PW:0] FULL_CNT = (PW+1)'(LOG_DEPTH);

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   frs_state_t state_r;
   logic [ERR_N-1:0] pend_r;
   logic [ERR_N-1:0] crit_hold_r;
   logic [CODE_W-1:0] log_mem [LOG_DEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [PW:0]   count_r;
   logic          ovf_r;
   logic          pop;
   logic          ack;

   // error classes
   logic [ERR_N-1:0] crit_ev;
   logic [ERR_N-1:0] norm_ev;
   logic [ERR_N-1:0] wr_onehot;
   logic [IW-1:0]    wr_idx;
   logic             release_crit;
   logic             serious_ev;

   assign crit_ev    = err_event_i & err_critical_i;
   assign norm_ev    = err_event_i & ~err_critical_i;
   // critical errors alert only at the end of the sequence
   assign serious_ev = |(norm_ev & err_serious_i); // RL3
   assign release_crit = (state_r == S_CAPTURE) || (state_r == S_FLAG) ||
                         (state_r == S_ALERT) || (state_r == S_HOLD);

   // lowest pending error is written first
   always_comb begin
      wr_idx    = '0;
      wr_onehot = '0;
      for (int i = ERR_N-1; i >= 0; i--) begin
         if (pend_r[i]) begin
            wr_idx    = IW'(i);
            wr_onehot = '0;
            wr_onehot[i] = 1'b1;
         end
      end
   end

   // pending set wins over the write that clears it
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         pend_r      <= '0;
         crit_hold_r <= '0;
      end else if (release_crit) begin
         pend_r      <= (pend_r & ~wr_onehot) | norm_ev | crit_ev | crit_hold_r; // RL6 RL10
         crit_hold_r <= '0;
      end else begin
         pend_r      <= (pend_r & ~wr_onehot) | norm_ev; // RL6
         crit_hold_r <= crit_hold_r | crit_ev;
      end
   end

   // log ring; full log drops the entry and flags overflow
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
         ovf_r    <= 1'b0;
      end else begin
         if (|pend_r && count_r != FULL_CNT) begin
            log_mem[wr_ptr_r] <= CODE_W'(wr_idx); // RL1
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop)
            rd_ptr_r <= rd_ptr_r + 1'b1;
         count_r <= count_r + (PW+1)'(|pend_r && count_r != FULL_CNT) - (PW+1)'(pop);
         if (|pend_r && count_r == FULL_CNT)
            ovf_r <= 1'b1;
         else if (ack)
            ovf_r <= 1'b0;
      end
   end

   // shutdown sequencer, one step at a time
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_r          <= S_IDLE;
         light_off_o      <= 1'b0;
         mirror_park_o    <= 1'b0;
         mirror_pwr_off_o <= 1'b0;
         standby_o        <= 1'b0;
         shutdown_o       <= 1'b0;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (|crit_ev || |crit_hold_r) begin
                  light_off_o <= 1'b1; // RL7 RL8
                  state_r     <= S_LIGHT;
               end
            end
            S_LIGHT: begin
               if (light_off_done_i) begin
                  mirror_park_o <= 1'b1; // RL8 RL12
                  state_r       <= S_PARK;
               end
            end
            S_PARK: begin
               if (mirror_parked_i) begin
                  mirror_pwr_off_o <= 1'b1; // RL8 RL12
                  state_r          <= S_POWER;
               end
            end
            S_POWER: begin
               if (mirror_off_done_i) begin
                  standby_o <= 1'b1; // RL9
                  state_r   <= S_STANDBY;
               end
            end
            S_STANDBY: state_r <= S_CAPTURE;
            S_CAPTURE: begin
               // wait until the causes sit in the log
               if (pend_r == '0 && crit_hold_r == '0) begin
                  shutdown_o <= 1'b1; // RL10 RL11
                  state_r    <= S_FLAG;
               end
            end
            S_FLAG:  state_r <= S_ALERT;
            S_ALERT: state_r <= S_HOLD;
            S_HOLD: begin
               if (ack) begin
                  light_off_o      <= 1'b0;
                  mirror_park_o    <= 1'b0;
                  mirror_pwr_off_o <= 1'b0;
                  standby_o        <= 1'b0;
                  shutdown_o       <= 1'b0;
                  state_r          <= S_IDLE;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // alert: set wins over the host acknowledge
   always_ff @(posedge clock_i) begin
      if (reset_i)
         alert_o <= 1'b0;
      else if (serious_ev || state_r == S_ALERT) // RL2 RL11
         alert_o <= 1'b1;
      else if (ack) // RL12
         alert_o <= 1'b0;
   end

   // pin synchroniser: three stages, accept once stages two and three agree
   logic [2:0] pin_s1_r;
   logic [2:0] pin_s2_r;
   logic [2:0] pin_s3_r;
   logic [2:0] pin_r;
   logic [2:0] pin_prev_r;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         pin_s1_r   <= PIN_IDLE;
         pin_s2_r   <= PIN_IDLE;
         pin_s3_r   <= PIN_IDLE;
         pin_r      <= PIN_IDLE;
         pin_prev_r <= PIN_IDLE;
      end else begin
         pin_s1_r   <= {spi_sck_i, spi_cs_n_i, spi_mosi_i};
         pin_s2_r   <= pin_s1_r;
         pin_s3_r   <= pin_s2_r;
         pin_r      <= (pin_s2_r & ~(pin_s2_r ^ pin_s3_r)) | (pin_r & (pin_s2_r ^ pin_s3_r));
         pin_prev_r <= pin_r;
      end
   end

   logic sel;
   logic sck_rise;
   logic sck_fall;
   assign sel      = ~pin_r[PIN_CS_N];
   assign sck_rise = sel & pin_r[PIN_SCK] & ~pin_prev_r[PIN_SCK];
   assign sck_fall = sel & ~pin_r[PIN_SCK] & pin_prev_r[PIN_SCK];

   // spi mode 0 slave; first byte is the command, then answer bytes
   logic [2:0] bit_cnt_r;
   logic [7:0] rx_sh_r;
   logic [7:0] tx_sh_r;
   logic [7:0] cmd_r;
   logic       cmd_valid_r;
   logic [7:0] rx_byte;
   logic       byte_done;
   logic [7:0] status;
   logic [7:0] head;
   logic [7:0] resp;

   assign rx_byte   = {rx_sh_r[6:0], pin_r[PIN_MOSI]};
   assign byte_done = sck_rise && bit_cnt_r == BIT_LAST;
   assign ack       = byte_done && !cmd_valid_r && rx_byte == CMD_ACK;
   assign pop       = byte_done && (cmd_valid_r ? cmd_r : rx_byte) == CMD_LOG &&
                      count_r != '0; // RL5

   always_comb begin
      status = '0;
      status[ST_ALERT_BIT] = alert_o;
      status[ST_SHUT_BIT]  = shutdown_o;
      status[ST_LOG_BIT]   = count_r != '0;
      status[ST_OVF_BIT]   = ovf_r;
      head = '0;
      if (count_r != '0) begin
         head[CODE_W-1:0]    = log_mem[rd_ptr_r];
         head[ENT_VALID_BIT] = 1'b1;
      end
      resp = frs_resp(cmd_valid_r ? cmd_r : rx_byte, status, head); // RL5
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         bit_cnt_r     <= '0;
         rx_sh_r       <= '0;
         tx_sh_r       <= '0;
         cmd_r         <= '0;
         cmd_valid_r   <= 1'b0;
         spi_miso_o    <= 1'b0;
         spi_miso_oe_o <= 1'b0;
      end else if (!sel) begin
         bit_cnt_r     <= '0;
         cmd_valid_r   <= 1'b0;
         spi_miso_oe_o <= 1'b0;
      end else begin
         spi_miso_oe_o <= 1'b1;
         if (sck_rise) begin
            rx_sh_r   <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (byte_done) begin
               // answer msb must stand before the next rising edge
               spi_miso_o <= resp[BYTE_W-1];
               tx_sh_r    <= {resp[6:0], 1'b0};
               if (!cmd_valid_r) begin
                  cmd_r       <= rx_byte;
                  cmd_valid_r <= 1'b1;
               end
            end
         end else if (sck_fall && bit_cnt_r != '0) begin
            spi_miso_o <= tx_sh_r[BYTE_W-1];
            tx_sh_r    <= {tx_sh_r[6:0], 1'b0};
         end
      end
   end

   // checks
   sequence seq_lights_out;
      light_off_o && !mirror_park_o;
   endsequence

   sequence seq_parked;
      mirror_park_o && !mirror_pwr_off_o;
   endsequence

   alert_serious_a : assert property ( // RL2
      serious_ev |=> alert_o)
      else $error("serious error did not raise alert");

   log_pending_a : assert property ( // RL6
      |norm_ev |=> ((pend_r & $past(norm_ev)) == $past(norm_ev)))
      else $error("error not queued for log");

   shut_start_a : assert property ( // RL7
      (state_r == S_IDLE && |crit_ev) |=> seq_lights_out)
      else $error("critical error did not start shutdown");

   park_order_a : assert property ( // RL8
      $rose(mirror_park_o) |-> light_off_o && $past(light_off_done_i))
      else $error("mirrors parked before lights off");

   power_order_a : assert property ( // RL12
      seq_parked ##1 $rose(mirror_pwr_off_o) |-> $past(mirror_parked_i))
      else $error("mirror power removed before park done");

   standby_step_a : assert property ( // RL9
      $rose(standby_o) |-> mirror_pwr_off_o ##1 state_r == S_CAPTURE)
      else $error("standby not entered in order");

   capture_first_a : assert property ( // RL10
      $rose(shutdown_o) |-> $past(pend_r) == '0 && $past(crit_hold_r) == '0)
      else $error("shutdown flag set before log capture");

   flag_alert_a : assert property ( // RL11
      $rose(shutdown_o) |-> (!alert_o || $past(alert_o)) ##2 alert_o)
      else $error("alert not asserted after shutdown flag");

   alert_hold_a : assert property ( // RL12
      alert_o && !ack |=> alert_o)
      else $error("alert dropped without acknowledge");

endmodule : frs_core

`default_nettype wire

/* core/frs_pkg.sv */
// constants, states and helpers for the fault report and shutdown block
// assumes one 100 MHz clock and a host reading the log over a spi slave port
// Contract
// (RL1) two report paths to host: readable error log and urgent alert line
// (RL2) alert line driven high when a serious error is detected; a critical one raises it only at the end of shutdown
// (RL3) serious means corrupt picture, too bright picture, or chipset damage
// (RL4) host should wire alert to an interrupt and service it there
// (RL5) error log readable over spi; host retrieves it that way
// (RL6) every detected error goes into the log, shutdown or not; the code drops it and sets the overflow bit when the log is full
// (RL7) critical errors also trigger emergency shutdown beyond logging
// (RL8) shutdown turns lights off, then parks mirrors, then removes their power
// (RL9) shutdown moves operating state to standby
// (RL10) shutdown stores causing errors in the log before signalling host
// (RL11) shutdown ends by setting status bit, then asserting alert
// (RL12) steps strictly ordered; alert stays high until host acknowledges
package frs_pkg;

   localparam int ERR_N_DEF     = 16;
   localparam int LOG_DEPTH_DEF = 16;
   localparam int CODE_W        = 7;
   localparam int BYTE_W        = 8;

   // spi command bytes
   localparam logic [7:0] CMD_STATUS = 8'h01;
   localparam logic [7:0] CMD_LOG    = 8'h02;
   localparam logic [7:0] CMD_ACK    = 8'h03;

   // status byte fields
   localparam int ST_ALERT_BIT = 0;
   localparam int ST_SHUT_BIT  = 1;
   localparam int ST_LOG_BIT   = 2;
   localparam int ST_OVF_BIT   = 3;

   // log entry: valid flag on top, error index below
   localparam int ENT_VALID_BIT = 7;

   // pin vector order and idle levels of the spi pins
   localparam int PIN_SCK  = 2;
   localparam int PIN_CS_N = 1;
   localparam int PIN_MOSI = 0;
   localparam logic [2:0] PIN_IDLE = 3'h2;
   localparam logic [2:0] BIT_LAST = 3'h7;

   typedef enum logic [3:0] {
      S_IDLE, S_LIGHT, S_PARK, S_POWER, S_STANDBY,
      S_CAPTURE, S_FLAG, S_ALERT, S_HOLD
   } frs_state_t;

   // answer byte for a command
   function automatic logic [7:0] frs_resp(input logic [7:0] cmd,
                                           input logic [7:0] status,
                                           input logic [7:0] head);
      logic [7:0] r;
      r = 8'h00;
      case (cmd)
         CMD_STATUS: r = status;
         CMD_LOG:    r = head;
         default:    r = 8'h00;
      endcase
      return r;
   endfunction : frs_resp

endpackage : frs_pkg

/* tb/fault_report_shutdown_test.sv */
// self-checking bench for the fault log, alert and shutdown sequencer
// assumes frs_core with default widths and frs_host_model as spi host
`timescale 1ns/100ps
`default_nettype none

module fault_report_shutdown_test;
   import frs_pkg::*;
   logic        clock_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [15:0] err_event_i = '0;
   logic [15:0] err_serious_i = '0;
   logic [15:0] err_critical_i = '0;
   logic        light_off_done_i = 1'b0;
   logic        mirror_parked_i = 1'b0;
   logic        mirror_off_done_i = 1'b0;
   logic        sck, cs_n, mosi, miso, miso_oe;
   logic        alert_o, light_off_o, mirror_park_o, mirror_pwr_off_o, standby_o, shutdown_o;
   int          n_fail = 0;
   int          comparisons = 0;
   logic [7:0]  b0, b1;

   always #5 clock_i = ~clock_i;

   frs_core i_dut (
      .clock_i(clock_i), .reset_i(reset_i), .err_event_i(err_event_i),
      .err_serious_i(err_serious_i), .err_critical_i(err_critical_i),
      .light_off_done_i(light_off_done_i), .mirror_parked_i(mirror_parked_i),
      .mirror_off_done_i(mirror_off_done_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
      .spi_mosi_i(mosi), .alert_o(alert_o), .light_off_o(light_off_o),
      .mirror_park_o(mirror_park_o), .mirror_pwr_off_o(mirror_pwr_off_o),
      .standby_o(standby_o), .shutdown_o(shutdown_o), .spi_miso_o(miso),
      .spi_miso_oe_o(miso_oe));

   frs_host_model i_host (
      .clock_i(clock_i), .spi_miso_i(miso), .spi_miso_oe_i(miso_oe), .spi_sck_o(sck),
      .spi_cs_n_o(cs_n), .spi_mosi_o(mosi));

   // light and mirror drivers answer one clock after each command
   always @(posedge clock_i) begin
      light_off_done_i  <= light_off_o;
      mirror_parked_i   <= mirror_park_o;
      mirror_off_done_i <= mirror_pwr_off_o;
   end

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic errs(input logic [15:0] ev, input logic [15:0] ser, input logic [15:0] crit);
      err_event_i    = ev;
      err_serious_i  = ser;
      err_critical_i = crit;
      @(posedge clock_i);
      #1;
      err_event_i    = '0;
      err_serious_i  = '0;
      err_critical_i = '0;
   endtask : errs

   task automatic read2(input logic [7:0] cmd, input string what, input logic [7:0] e0,
                        input logic [7:0] e1);
      i_host.frame(cmd, b0, b1);
      check({what, " first"}, e0, b0);
      check({what, " second"}, e1, b1);
      check({what, " oe"}, 8'h01, {7'h0, i_host.oe_ok});
      check({what, " oe idle"}, 8'h00, {7'h0, miso_oe});
   endtask : read2

   task automatic serious_error;
      errs(16'h0008, 16'h0008, 16'h0000);
      @(posedge clock_i);
      #1;
      check("alert", 8'h01, {7'h0, alert_o});
      check("shutdown", 8'h00, {7'h0, shutdown_o});
      read2(CMD_STATUS, "status", 8'h05, 8'h05);
      read2(CMD_LOG, "log", 8'h83, 8'h00);
      read2(CMD_ACK, "ack", 8'h00, 8'h00);
      check("alert after ack", 8'h00, {7'h0, alert_o});
   endtask : serious_error

   task automatic minor_errors;
      errs(16'h0044, 16'h0000, 16'h0000);
      repeat (4) @(posedge clock_i);
      #1;
      check("alert minor", 8'h00, {7'h0, alert_o});
      read2(CMD_LOG, "log pair", 8'h82, 8'h86);
   endtask : minor_errors

   task automatic critical_error;
      int         t[6];
      logic [5:0] v;
      t = '{-1, -1, -1, -1, -1, -1};
      errs(16'h0200, 16'h0200, 16'h0200);
      for (int k = 0; k < 300 && t[5] < 0; k++) begin
         @(posedge clock_i);
         #1;
         v = {alert_o, shutdown_o, standby_o, mirror_pwr_off_o, mirror_park_o, light_off_o};
         for (int j = 0; j < 6; j++) if (v[j] && t[j] < 0) t[j] = k;
      end
      for (int j = 1; j < 6; j++) check("step order", 8'h01, {7'h0, t[j] > t[j-1]});
      repeat (50) @(posedge clock_i);
      #1;
      // the host services the alert line here, as its interrupt would
      v = {alert_o, shutdown_o, standby_o, mirror_pwr_off_o, mirror_park_o, light_off_o};
      check("held outputs", 8'h3f, {2'b0, v});
      check("standby", 8'h01, {7'h0, standby_o});
      read2(CMD_STATUS, "status shut", 8'h07, 8'h07);
      read2(CMD_LOG, "log shut", 8'h89, 8'h00);
      read2(CMD_ACK, "ack shut", 8'h00, 8'h00);
      v = {alert_o, shutdown_o, standby_o, mirror_pwr_off_o, mirror_park_o, light_off_o};
      check("released", 8'h00, {2'b0, v});
   endtask : critical_error

   task automatic log_overflow;
      errs(16'hffff, 16'h0000, 16'h0000);
      repeat (20) @(posedge clock_i);
      #1;
      errs(16'h0001, 16'h0000, 16'h0000);
      repeat (4) @(posedge clock_i);
      #1;
      read2(CMD_STATUS, "status full", 8'h0c, 8'h0c);
      read2(CMD_LOG, "log full", 8'h80, 8'h81);
      // last answer byte of a frame pops an entry the host never sees
      read2(CMD_LOG, "log after", 8'h83, 8'h84);
      read2(CMD_ACK, "ack full", 8'h00, 8'h00);
      read2(CMD_STATUS, "status ack", 8'h04, 8'h04);
   endtask : log_overflow

   task automatic stop_test;
      if (n_fail == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (12) @(posedge clock_i);
      #1;
      reset_i = 1'b0;
      repeat (8) @(posedge clock_i);
      #1;
      serious_error();
      minor_errors();
      critical_error();
      log_overflow();
      stop_test();
   end

   // about 12 frames of 511 clocks each, with margin
   initial begin
      #500us;
      n_fail++;
      stop_test();
   end
endmodule : fault_report_shutdown_test

`default_nettype wire

/* tb/frs_host_model.sv */
// host side of the fault port: spi master, mode 0, msb first
// assumes the block's clock; the host shifts only inside frames
`timescale 1ns/100ps
`default_nettype none

module frs_host_model (
   input  wire logic clock_i,
   input  wire logic spi_miso_i,
   input  wire logic spi_miso_oe_i,
   output logic      spi_sck_o,
   output logic      spi_cs_n_o,
   output logic      spi_mosi_o
);
   // half period of sck in clocks, above the sync minimum of 5
   localparam int HALF = 10;

   // stays high only if the block drove miso at every rising sck of the frame
   logic oe_ok;

   initial begin
      spi_sck_o  = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_mosi_o = 1'b0;
      oe_ok      = 1'b0;
   end

   task automatic half_wait;
      repeat (HALF) @(posedge clock_i);
      #1;
   endtask : half_wait

   // one frame: command byte, then two answer bytes
   task automatic frame(input logic [7:0] cmd, output logic [7:0] a0, output logic [7:0] a1);
      logic [23:0] tx;
      logic [23:0] rx;
      tx = {cmd, 16'h0000};
      rx = 24'h000000;
      @(posedge clock_i);
      #1;
      spi_cs_n_o = 1'b0;
      oe_ok = 1'b1;
      half_wait();
      for (int i = 23; i >= 0; i--) begin
         spi_mosi_o = tx[i];
         half_wait();
         spi_sck_o = 1'b1;
         rx = {rx[22:0], spi_miso_i};
         oe_ok = oe_ok & spi_miso_oe_i;
         half_wait();
         spi_sck_o = 1'b0;
      end
      half_wait();
      spi_cs_n_o = 1'b1;
      // released line: no pull, so show a changed level
      spi_mosi_o = ~spi_mosi_o;
      half_wait();
      a0 = rx[15:8];
      a1 = rx[7:0];
   endtask : frame
endmodule : frs_host_model

`default_nettype wire
